// ---- design/gpio_mux_pkg.sv ----
// constants shared by the gpio block and its bench
// assumes a single 100 mhz clock and a synchronous active-high reset
//
// Notes on behaviour
// - thirty-six pins in five ports: a, b, c, d (four bits) and l.
// - every pin has its own direction bit, input or output.
// - port c inputs pull up or down; other ports pull up only.
// - port c outputs may be open-drain or push-pull; others push-pull only.
// - port a inputs have an optional debounce filter enabled by software.
// - port a flags a change on either edge of any input.
// - direction, pull and drive stay software settings under alternate functions.
// - port l bits 0 to 3 may carry lcd data bits 0 to 3.
// - port l bits 4 to 7: shift clock, alternate drive, line latch, frame.
// - port b: chip selects 1 to 3, timer 0, then led drives 0 to 3.
// - port c bits 0 to 4: spi select, clock, miso, mosi, ready low.
// - port c bits 0 to 3 may instead be serial eeprom select, clock, in, out.
// - port d: timer 2 on bit 3, timer 1, second load, source clock.
// - port d bits 0 to 3 are edge-triggered external interrupts.
package gpio_mux_pkg;

    // -----------------------------------------------------------------
    // port shape
    // -----------------------------------------------------------------
    localparam int PORT_WIDTH   = 8;
    localparam int PORT_D_WIDTH = 4;
    localparam int PIN_COUNT    = 4 * PORT_WIDTH + PORT_D_WIDTH;

    // -----------------------------------------------------------------
    // timing
    // -----------------------------------------------------------------
    localparam int CLK_PERIOD_NS     = 10;
    localparam int DEBOUNCE_TICK_NS  = 1000;
    localparam int DEBOUNCE_TICK_CYC = DEBOUNCE_TICK_NS / CLK_PERIOD_NS;
    localparam int DEBOUNCE_SAMPLES  = 3;

    // -----------------------------------------------------------------
    // values after reset
    // -----------------------------------------------------------------
    localparam logic [7:0] RESET_BYTE = 8'h00;
    localparam logic [3:0] RESET_NIB  = 4'h0;

endpackage

// ---- design/gpio_ports_with_pin_mux.sv ----
// gpio ports a, b, c, d and l with pin multiplexing, debounce and edge events
// assumes configuration bits come straight from a cpu-side register block,
// and pad inputs are already synchronous to sys_clk
module gpio_ports_with_pin_mux #(
    parameter int DEB_TICK = gpio_mux_pkg::DEBOUNCE_TICK_CYC
) (
    input  wire logic                                sys_clk,
    input  wire logic                                reset,
    // pad side, one bit per pin
    input  wire logic [gpio_mux_pkg::PORT_WIDTH-1:0]   pa_in,
    input  wire logic [gpio_mux_pkg::PORT_WIDTH-1:0]   pb_in,
    input  wire logic [gpio_mux_pkg::PORT_WIDTH-1:0]   pc_in,
    input  wire logic [gpio_mux_pkg::PORT_D_WIDTH-1:0] pd_in,
    input  wire logic [gpio_mux_pkg::PORT_WIDTH-1:0]   pl_in,
    output logic      [gpio_mux_pkg::PIN_COUNT-1:0]    pad_out,
    output logic      [gpio_mux_pkg::PIN_COUNT-1:0]    pad_oe,
    output logic      [gpio_mux_pkg::PIN_COUNT-1:0]    pad_pull_up,
    output logic      [gpio_mux_pkg::PIN_COUNT-1:0]    pad_pull_down,
    // software settings, packed a, b, c, d, l from bit 0 upward
    input  wire logic [gpio_mux_pkg::PIN_COUNT-1:0]    pin_dir_out,
    input  wire logic [gpio_mux_pkg::PIN_COUNT-1:0]    pin_data,
    input  wire logic [gpio_mux_pkg::PIN_COUNT-1:0]    pin_pull_en,
    input  wire logic [gpio_mux_pkg::PIN_COUNT-1:0]    pin_alt_en,
    input  wire logic [gpio_mux_pkg::PORT_WIDTH-1:0]   pc_pull_down_sel,
    input  wire logic [gpio_mux_pkg::PORT_WIDTH-1:0]   pc_open_drain,
    input  wire logic [gpio_mux_pkg::PORT_WIDTH-1:0]   pc_eeprom_sel,
    input  wire logic                                  pa_debounce_en,
    input  wire logic [gpio_mux_pkg::PORT_D_WIDTH-1:0] ext_int_rising,
    // alternate function sources
    input  wire logic [3:0]                            lcd_data,
    input  wire logic                                  lcd_shift_clock,
    input  wire logic                                  lcd_alternate_drive,
    input  wire logic                                  lcd_line_latch,
    input  wire logic                                  lcd_frame_marker,
    input  wire logic                                  mem_chip_select_one,
    input  wire logic                                  mem_chip_select_two,
    input  wire logic                                  mem_chip_select_three,
    input  wire logic                                  timer0_out,
    input  wire logic [3:0]                            led_drive,
    input  wire logic                                  spi_select,
    input  wire logic                                  spi_clock,
    input  wire logic                                  spi_miso,
    input  wire logic                                  spi_mosi,
    input  wire logic                                  spi_ready_n,
    input  wire logic                                  eeprom_select,
    input  wire logic                                  eeprom_clock,
    input  wire logic                                  eeprom_data_in,
    input  wire logic                                  eeprom_data_out,
    input  wire logic                                  timer2_out,
    input  wire logic                                  timer1_out,
    input  wire logic                                  lcd_second_load,
    input  wire logic                                  sys_source_clock,
    // state back to software
    output logic      [gpio_mux_pkg::PIN_COUNT-1:0]    pin_level,
    output logic      [gpio_mux_pkg::PORT_WIDTH-1:0]   pa_filtered,
    output logic      [gpio_mux_pkg::PORT_WIDTH-1:0]   pa_change,
    output logic                                       pa_change_any,
    output logic      [gpio_mux_pkg::PORT_D_WIDTH-1:0] ext_int_event
);
    import gpio_mux_pkg::*;

    // -----------------------------------------------------------------
    // elaboration check
    // -----------------------------------------------------------------
    if (DEB_TICK < 2) begin : g_bad_tick
        $error("debounce tick must be at least two cycles");
    end

    localparam int TW = $clog2(DEB_TICK + 1);
    localparam int B0 = PORT_WIDTH;
    localparam int C0 = 2 * PORT_WIDTH;
    localparam int D0 = 3 * PORT_WIDTH;
    localparam int L0 = 3 * PORT_WIDTH + PORT_D_WIDTH;

    // -----------------------------------------------------------------
    // alternate function values per pin
    // -----------------------------------------------------------------
    wire logic [PORT_WIDTH-1:0]   alt_b;
    wire logic [PORT_WIDTH-1:0]   alt_c;
    wire logic [PORT_WIDTH-1:0]   spi_c;
    wire logic [PORT_WIDTH-1:0]   eep_c;
    wire logic [PORT_D_WIDTH-1:0] alt_d;
    wire logic [PORT_WIDTH-1:0]   alt_l;
    wire logic [PIN_COUNT-1:0]    alt_all;
    wire logic [PIN_COUNT-1:0]    alt_ok;
    wire logic [PIN_COUNT-1:0]    src;
    wire logic [PIN_COUNT-1:0]    pad_in_all;
    wire logic [PIN_COUNT-1:0]    is_port_c;
    wire logic [PIN_COUNT-1:0]    od_all;
    wire logic [PIN_COUNT-1:0]    dn_all;

    assign alt_b = {led_drive, timer0_out, mem_chip_select_three,
                    mem_chip_select_two, mem_chip_select_one};
    assign spi_c = {3'h0, spi_ready_n, spi_mosi, spi_miso, spi_clock, spi_select};
    assign eep_c = {4'h0, eeprom_data_out, eeprom_data_in, eeprom_clock,
                    eeprom_select};
    assign alt_c = (pc_eeprom_sel & eep_c) | (~pc_eeprom_sel & spi_c);
    assign alt_d = {timer2_out, timer1_out, lcd_second_load, sys_source_clock};
    assign alt_l = {lcd_frame_marker, lcd_line_latch, lcd_alternate_drive,
                    lcd_shift_clock, lcd_data};
    assign alt_all = {alt_l, alt_d, alt_c, alt_b, RESET_BYTE};

    // port a and the unused high bits of port c (and bits 4+ under eeprom)
    // have no alternate source, so their alt enable falls back to gpio data
    assign alt_ok = {{PORT_WIDTH{1'b1}}, {PORT_D_WIDTH{1'b1}},
                     3'h0, ~pc_eeprom_sel[4], 4'hf,
                     {PORT_WIDTH{1'b1}}, RESET_BYTE};
    assign src = pin_alt_en & alt_ok;
    assign pad_in_all = {pl_in, pd_in, pc_in, pb_in, pa_in};
    assign is_port_c  = {{(PORT_D_WIDTH + PORT_WIDTH){1'b0}}, {PORT_WIDTH{1'b1}},
                         {(2 * PORT_WIDTH){1'b0}}};
    assign od_all = {{(PORT_D_WIDTH + PORT_WIDTH){1'b0}}, pc_open_drain,
                     {(2 * PORT_WIDTH){1'b0}}};
    assign dn_all = {{(PORT_D_WIDTH + PORT_WIDTH){1'b0}}, pc_pull_down_sel,
                     {(2 * PORT_WIDTH){1'b0}}};

    // -----------------------------------------------------------------
    // pad drive: direction, pull and drive remain software's even
    // when the value comes from a peripheral
    // -----------------------------------------------------------------
    wire logic [PIN_COUNT-1:0] value;
    wire logic [PIN_COUNT-1:0] next_out;
    wire logic [PIN_COUNT-1:0] next_oe;
    wire logic [PIN_COUNT-1:0] next_up;
    wire logic [PIN_COUNT-1:0] next_dn;

    assign value    = (src & alt_all) | (~src & pin_data);
    assign next_oe  = pin_dir_out & ~(od_all & value);
    assign next_out = value & ~od_all;
    assign next_up  = ~pin_dir_out & pin_pull_en & ~dn_all;
    assign next_dn  = ~pin_dir_out & pin_pull_en & dn_all & is_port_c;

    // settings are registered, so reset forces inputs with pulls off
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            pad_out       <= '0;
            pad_oe        <= '0;
            pad_pull_up   <= '0;
            pad_pull_down <= '0;
            pin_level     <= '0;
        end else begin
            pad_out       <= next_out;
            pad_oe        <= next_oe;
            pad_pull_up   <= next_up;
            pad_pull_down <= next_dn;
            pin_level     <= pad_in_all;
        end
    end

    // -----------------------------------------------------------------
    // port a debounce: a shared tick, each bit accepted after
    // three equal samples; slow but costs one counter for all bits
    // -----------------------------------------------------------------
    logic [TW-1:0] tick_cnt;
    wire logic     tick;
    logic [PORT_WIDTH-1:0] deb;
    logic [PORT_WIDTH-1:0] pa_prev;
    wire logic [PORT_WIDTH-1:0] next_filt;

    assign tick = (tick_cnt == TW'(DEB_TICK - 1));

    always_ff @(posedge sys_clk) begin
        if (reset || tick) begin
            tick_cnt <= '0;
        end else begin
            tick_cnt <= tick_cnt + TW'(1);
        end
    end

    for (genvar i = 0; i < PORT_WIDTH; i++) begin : g_deb
        logic [DEBOUNCE_SAMPLES-1:0] hist;
        wire logic                   settled;
        assign settled = (hist == {DEBOUNCE_SAMPLES{hist[0]}});
        always_ff @(posedge sys_clk) begin
            if (reset) begin
                hist   <= '0;
                deb[i] <= 1'b0;
            end else if (tick) begin
                hist <= {hist[DEBOUNCE_SAMPLES-2:0], pa_in[i]};
                if (settled) begin
                    deb[i] <= hist[0];
                end
            end
        end
    end

    assign next_filt = pa_debounce_en ? deb : pa_in;

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            pa_prev       <= RESET_BYTE;
            pa_filtered   <= RESET_BYTE;
            pa_change     <= RESET_BYTE;
            pa_change_any <= 1'b0;
        end else begin
            pa_prev       <= next_filt;
            pa_filtered   <= next_filt;
            pa_change     <= next_filt ^ pa_prev;
            pa_change_any <= |(next_filt ^ pa_prev);
        end
    end

    // -----------------------------------------------------------------
    // port d external edge events
    // -----------------------------------------------------------------
    logic [PORT_D_WIDTH-1:0] pd_prev;
    wire logic [PORT_D_WIDTH-1:0] next_evt;

    assign next_evt = (ext_int_rising & pd_in & ~pd_prev)
                    | (~ext_int_rising & ~pd_in & pd_prev);

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            pd_prev       <= RESET_NIB;
            ext_int_event <= RESET_NIB;
        end else begin
            pd_prev       <= pd_in;
            ext_int_event <= next_evt;
        end
    end

    // -----------------------------------------------------------------
    // checks
    // -----------------------------------------------------------------
    reset_input_a: assert property (@(posedge sys_clk)
        reset |=> (pad_oe == '0) && (pad_out == '0))
        else $error("pins not inputs after reset");

    od_high_a: assert property (@(posedge sys_clk) disable iff (reset)
        !(pad_oe[C0] && pad_out[C0] && $past(pc_open_drain[0])))
        else $error("open-drain pin drove high");

    input_no_drive_a: assert property (@(posedge sys_clk) disable iff (reset)
        !$past(pin_dir_out[0]) |-> !pad_oe[0])
        else $error("input pin enabled its driver");

    pull_excl_a: assert property (@(posedge sys_clk) disable iff (reset)
        (pad_pull_down & ~is_port_c) == '0 && (pad_pull_up & pad_pull_down) == '0)
        else $error("illegal pull combination");

    lcd_clock_a: assert property (@(posedge sys_clk) disable iff (reset)
        $past(pin_alt_en[L0+4] && pin_dir_out[L0+4] && !reset)
        |-> pad_out[L0+4] == $past(lcd_shift_clock))
        else $error("lcd shift clock not on port l bit 4");

    led_mux_a: assert property (@(posedge sys_clk) disable iff (reset)
        $past(pin_alt_en[B0+7] && !reset) |-> pad_out[B0+7] == $past(led_drive[3]))
        else $error("led 3 not on port b bit 7");

    pa_change_a: assert property (@(posedge sys_clk) disable iff (reset)
        (!pa_debounce_en && $past(!reset) && pa_in[0] != $past(pa_in[0]))
        |=> pa_change[0] && pa_change_any)
        else $error("port a change missed");

    // a second pulse is only legal when the polarity flipped to falling meanwhile
    ext_edge_a: assert property (@(posedge sys_clk) disable iff (reset)
        (ext_int_rising[3] && $rose(pd_in[3]) && $past(!reset))
        |=> ext_int_event[3] ##1 (!ext_int_event[3] || !$past(ext_int_rising[3])))
        else $error("port d edge event wrong");

    deb_hold_a: assert property (@(posedge sys_clk) disable iff (reset)
        !tick |=> deb == $past(deb))
        else $error("debounced value moved off tick");

    level_copy_a: assert property (@(posedge sys_clk) disable iff (reset)
        $past(!reset) |-> pin_level == $past(pad_in_all))
        else $error("pin level not a copy of the pads");

    gpio_data_a: assert property (@(posedge sys_clk) disable iff (reset)
        $past(!pin_alt_en[B0] && !reset) |-> pad_out[B0] == $past(pin_data[B0]))
        else $error("gpio data not on port b bit 0");

    pc_pull_down_a: assert property (@(posedge sys_clk) disable iff (reset)
        $past(!pin_dir_out[C0+1] && pin_pull_en[C0+1] && pc_pull_down_sel[1] && !reset)
        |-> pad_pull_down[C0+1] && !pad_pull_up[C0+1])
        else $error("port c pull-down not applied");

    alt_dir_a: assert property (@(posedge sys_clk) disable iff (reset)
        $past(pin_alt_en[B0+3] && !pin_dir_out[B0+3] && !reset) |-> !pad_oe[B0+3])
        else $error("alternate function overrode direction");

    lcd_data_a: assert property (@(posedge sys_clk) disable iff (reset)
        $past(pin_alt_en[L0] && !reset) |-> pad_out[L0] == $past(lcd_data[0]))
        else $error("lcd data 0 not on port l bit 0");

    spi_clock_a: assert property (@(posedge sys_clk) disable iff (reset)
        $past(pin_alt_en[C0+1] && !pc_eeprom_sel[1] && !pc_open_drain[1] && !reset)
        |-> pad_out[C0+1] == $past(spi_clock))
        else $error("spi clock not on port c bit 1");

    eeprom_out_a: assert property (@(posedge sys_clk) disable iff (reset)
        $past(pin_alt_en[C0+3] && pc_eeprom_sel[3] && !pc_open_drain[3] && !reset)
        |-> pad_out[C0+3] == $past(eeprom_data_out))
        else $error("eeprom data out not on port c bit 3");

    timer2_pin_a: assert property (@(posedge sys_clk) disable iff (reset)
        $past(pin_alt_en[D0+3] && !reset) |-> pad_out[D0+3] == $past(timer2_out))
        else $error("timer 2 not on port d bit 3");

    ext_fall_a: assert property (@(posedge sys_clk) disable iff (reset)
        (!ext_int_rising[1] && $fell(pd_in[1]) && $past(!reset)) |=> ext_int_event[1])
        else $error("falling edge event missed");

endmodule

// ---- verification/pad_model.sv ----
// pad and far-side model: keypad, leds, lcd driver and serial parts on the pins
// assumes pad_* come from the gpio block and ext_* are set by the bench
module pad_model (
    input  wire logic                            sys_clk,
    input  wire logic [gpio_mux_pkg::PIN_COUNT-1:0] pad_out,
    input  wire logic [gpio_mux_pkg::PIN_COUNT-1:0] pad_oe,
    input  wire logic [gpio_mux_pkg::PIN_COUNT-1:0] pad_pull_up,
    input  wire logic [gpio_mux_pkg::PIN_COUNT-1:0] pad_pull_down,
    input  wire logic [gpio_mux_pkg::PIN_COUNT-1:0] ext_en,
    input  wire logic [gpio_mux_pkg::PIN_COUNT-1:0] ext_val,
    output logic      [gpio_mux_pkg::PIN_COUNT-1:0] level
);
    timeunit 1ns;
    timeprecision 1ps;
    import gpio_mux_pkg::*;
    // a floating pin must not look stable, so its level flips every cycle
    logic [PIN_COUNT-1:0] drift = 36'h0;
    always @(posedge sys_clk) begin
        drift <= ~drift;
    end
    always_comb begin
        for (int i = 0; i < PIN_COUNT; i++) begin
            if (pad_oe[i])
                level[i] = pad_out[i];
            else if (ext_en[i])
                level[i] = ext_val[i];
            else if (pad_pull_up[i])
                level[i] = 1'b1;
            else if (pad_pull_down[i])
                level[i] = 1'b0;
            else
                level[i] = drift[i];
        end
    end
endmodule

// ---- verification/testbench.sv ----
// self-checking bench for the gpio ports with pin multiplexing
// assumes the pad model resolves every pin; debounce tick shortened to 4 cycles
`define CHK(got, exp) begin cmp_count++; if ((got) !== (exp)) begin errors++; \
    $display("[FAIL] t=%0t got %h exp %h", $time, got, exp); end end
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    import gpio_mux_pkg::*;
    logic                 sys_clk = 1'b0;
    logic                 reset   = 1'b1;
    logic [PIN_COUNT-1:0] dir = 36'h0, dat = 36'h0, pen = 36'h0, aen = 36'h0;
    logic [PIN_COUNT-1:0] ext_en = 36'hf_ffff_ffff, ext_val = 36'h0, lvl;
    logic [PIN_COUNT-1:0] pout, poe, ppu, ppd, plev;
    logic [7:0]           pcpd = 8'h00, pcod = 8'h00, pcee = 8'h00, pa_f, pa_c;
    logic [3:0]           rise = 4'h0, ev;
    logic                 deb = 1'b0, pa_any;
    logic [28:0]          alt = 29'h0;
    int                   errors = 0, cmp_count = 0;
    gpio_ports_with_pin_mux #(.DEB_TICK(4)) u_dut (
        .sys_clk(sys_clk), .reset(reset), .pa_in(lvl[7:0]), .pb_in(lvl[15:8]),
        .pc_in(lvl[23:16]), .pd_in(lvl[27:24]), .pl_in(lvl[35:28]),
        .pad_out(pout), .pad_oe(poe), .pad_pull_up(ppu), .pad_pull_down(ppd),
        .pin_dir_out(dir), .pin_data(dat), .pin_pull_en(pen), .pin_alt_en(aen),
        .pc_pull_down_sel(pcpd), .pc_open_drain(pcod), .pc_eeprom_sel(pcee),
        .pa_debounce_en(deb), .ext_int_rising(rise),
        .lcd_data(alt[3:0]), .lcd_shift_clock(alt[4]), .lcd_alternate_drive(alt[5]),
        .lcd_line_latch(alt[6]), .lcd_frame_marker(alt[7]), .mem_chip_select_one(alt[8]),
        .mem_chip_select_two(alt[9]), .mem_chip_select_three(alt[10]),
        .timer0_out(alt[11]), .led_drive(alt[15:12]), .spi_select(alt[16]),
        .spi_clock(alt[17]), .spi_miso(alt[18]), .spi_mosi(alt[19]),
        .spi_ready_n(alt[20]), .eeprom_select(alt[21]), .eeprom_clock(alt[22]),
        .eeprom_data_in(alt[23]), .eeprom_data_out(alt[24]), .timer2_out(alt[25]),
        .timer1_out(alt[26]), .lcd_second_load(alt[27]), .sys_source_clock(alt[28]),
        .pin_level(plev), .pa_filtered(pa_f), .pa_change(pa_c),
        .pa_change_any(pa_any), .ext_int_event(ev));
    pad_model u_pads (.sys_clk(sys_clk), .pad_out(pout), .pad_oe(poe), .pad_pull_up(ppu),
        .pad_pull_down(ppd), .ext_en(ext_en), .ext_val(ext_val), .level(lvl));
    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    initial begin
        forever #5 sys_clk = ~sys_clk;
    end
    task cyc(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask
    task test_done;
        $display("comparisons %0d mismatches %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    // port a level step; the change flag must appear in lo..hi cycles
    task pa_edge(input logic [7:0] v, input logic [7:0] exp, input int lo, input int hi);
        int k;
        @(posedge sys_clk);
        ext_val[7:0] <= v;
        k = 0;
        do begin
            cyc(1);
            k++;
        end while (pa_any !== 1'b1 && k < hi);
        `CHK(1'(k >= lo), 1'b1)
        `CHK(pa_c, exp)
        `CHK(pa_f, v)
        cyc(1);
        `CHK(pa_any, 1'b0)
    endtask
    task pd_edge(input logic [3:0] v, input logic [3:0] exp);
        int k;
        @(posedge sys_clk);
        ext_val[27:24] <= v;
        k = 0;
        do begin
            cyc(1);
            k++;
        end while (ev === 4'h0 && k < 4);
        `CHK(ev, exp)
        cyc(1);
        `CHK(ev, 4'h0)
    endtask
    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task t_gpio;
        @(posedge sys_clk);
        dir <= 36'h9_3c5a_a5c3;
        dat <= 36'hf_ffff_ffff;
        ext_val <= 36'h5_5555_5555;
        cyc(3);
        `CHK(poe, 36'h9_3c5a_a5c3)
        `CHK(pout & dir, dir)
        `CHK(plev, (dir & dat) | (~dir & ext_val))
        @(posedge sys_clk);
        dat <= 36'h0;
        ext_val <= 36'h0;
        cyc(3);
        `CHK(pout & dir, 36'h0)
        @(posedge sys_clk);
        dir <= 36'h0;
    endtask
    task t_pull;
        @(posedge sys_clk);
        ext_en <= 36'h0;
        pen <= 36'hf_ffff_ffff;
        pcpd <= 8'hff;
        cyc(3);
        `CHK(ppu, 36'hf_ff00_ffff)
        `CHK(ppd, 36'h0_00ff_0000)
        `CHK(plev, 36'hf_ff00_ffff)
        @(posedge sys_clk);
        pcpd <= 8'h0f;
        cyc(2);
        `CHK(ppd, 36'h0_000f_0000)
        @(posedge sys_clk);
        dir <= 36'hf_ffff_ffff;
        cyc(2);
        `CHK(ppu | ppd, 36'h0)
        @(posedge sys_clk);
        dir <= 36'h0;
        pen <= 36'h0;
        pcpd <= 8'h00;
        ext_en <= 36'hf_ffff_ffff;
    endtask
    task t_drain;
        @(posedge sys_clk);
        dir <= 36'h0_00ff_ff00;
        dat <= 36'h0_000f_0f00;
        pcod <= 8'hff;
        cyc(2);
        `CHK(poe[23:16], 8'hf0)
        `CHK(pout[23:16], 8'h00)
        `CHK({poe[15:8], pout[15:8]}, 16'hff0f)
        @(posedge sys_clk);
        pcod <= 8'h00;
        dat <= 36'h0;
    endtask
    task t_alt;
        @(posedge sys_clk);
        dir <= 36'hf_ffff_ffff;
        aen <= 36'hf_ffff_ffff;
        dat <= 36'h0_0000_00a5;
        alt <= {4'h9, 4'h6, 5'h13, 4'h6, 4'hd, 8'h5a};
        cyc(2);
        `CHK(pout[35:28], 8'h5a)
        `CHK(pout[15:8], 8'h6d)
        `CHK(pout[23:16], 8'h13)
        `CHK(pout[27:24], 4'h9)
        `CHK(pout[7:0], 8'ha5)
        @(posedge sys_clk);
        pcee <= 8'h1f;
        cyc(2);
        `CHK(pout[23:16], 8'h06)
        @(posedge sys_clk);
        dir <= 36'h0;
        pen <= 36'hf_ffff_ffff;
        cyc(2);
        `CHK(poe, 36'h0)
        `CHK(ppu, 36'hf_ffff_ffff)
        @(posedge sys_clk);
        aen <= 36'h0;
        pen <= 36'h0;
        dat <= 36'h0;
        pcee <= 8'h00;
    endtask
    task t_port_a;
        int hits;
        pa_edge(8'h01, 8'h01, 1, 3);
        pa_edge(8'h81, 8'h80, 1, 3);
        pa_edge(8'h80, 8'h01, 1, 3);
        @(posedge sys_clk);
        deb <= 1'b1;
        cyc(30);
        // a one-cycle glitch must be filtered out entirely
        @(posedge sys_clk);
        ext_val[2] <= 1'b1;
        @(posedge sys_clk);
        ext_val[2] <= 1'b0;
        hits = 0;
        repeat (30) begin
            cyc(1);
            if (pa_any === 1'b1)
                hits++;
        end
        `CHK(32'(hits), 32'h0)
        pa_edge(8'h84, 8'h04, 12, 20);
    endtask
    task t_int;
        @(posedge sys_clk);
        rise <= 4'hd;
        cyc(3);
        pd_edge(4'hf, 4'hd);
        pd_edge(4'h0, 4'h2);
    endtask
    initial begin
        fork
            begin
                #200000;
                errors++;
                test_done();
            end
        join_none
        repeat (16) @(posedge sys_clk);
        reset <= 1'b0;
        cyc(1);
        `CHK({poe, pout, ppu, ppd}, 144'h0)
        t_gpio();
        t_pull();
        t_drain();
        t_alt();
        t_port_a();
        t_int();
        test_done();
    end
endmodule
